/* File: crcg_pkg.sv */
package crcg_pkg;
  // Register index map
  localparam logic [1:0] ADDR_CTRL = 2'h0;
  localparam logic [1:0] ADDR_TAPS = 2'h1;
  localparam logic [1:0] ADDR_CHECKSUM = 2'h2;
  localparam logic [1:0] ADDR_FIFO_WR = 2'h3;
  // Field positions in control_status_reg
  localparam int POLY_LENGTH_MINUS_ONE_LSB = 0;
  localparam int RUN_BIT = 4;
  localparam int EMPTY_BIT = 6;
  localparam int FULL_BIT = 7;
  localparam int COUNT_LSB = 8;
  localparam int IDLE_STOP_BIT = 13;
  // Widths and depths
  localparam int DATA_W = 16;
  localparam int FIFO_ENTRIES = 16;
  localparam logic [4:0] DEPTH_LONG = 5'h08;
  localparam logic [4:0] DEPTH_SHORT = 5'h10;
  localparam logic [3:0] POLY_LENGTH_MINUS_ONE_SHORT_MAX = 4'h7;
  localparam logic [3:0] POLY_LENGTH_MINUS_ONE_TOP = 4'hF;
  // Reset values and masks
  localparam logic [3:0] POLY_LENGTH_MINUS_ONE_RST = 4'h0;
  localparam logic RUN_RST = 1'b0;
  localparam logic IDLE_STOP_RST = 1'b0;
  localparam logic [15:0] TAPS_RST = 16'h0000;
  localparam logic [15:0] CRC_RST = 16'h0000;
  localparam logic [15:0] TAPS_MASK = 16'hFFFE;
  localparam logic [15:0] ALL_ONES = 16'hFFFF;
endpackage : crcg_pkg

/* File: crcg_top.sv */
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
// Summary of operation
// R1: Four-bit length field holds polynomial length minus one; sets word size.
// R2: Fifteen tap enables for terms tap_enable; bit 0 reads zero.
// R3: Constant x0 term always applies feedback.
// R4: Top term of a 16-bit polynomial is implied, no tap bit.
// R5: FIFO depth is 8 when length field above 7, else 16.
// R6: FIFO accepts byte writes; wide words built from partial writes.
// R7: Writing the word's most significant bit adds one valid word.
// R8: Shifting runs only while run bit set and count above zero.
// R9: Count drops as each word's last bit leaves; shifting continues to zero.
// R10: Each queued word takes length field plus one clocks, one bit each.
// R11: Full flag at count equal to depth; empty flag at zero.
// R12: Write while full wraps count to zero, no interrupt.
// R13: Interrupt when count goes from one to zero.
// R14: Run bit one starts the shifter; zero stops it.
// R15: Software waits one cycle after a data write before reading count.
// R16: Software waits for empty before reading the checksum.
// R17: Software flushes queued words by running until empty.
// R18: Software primes FIFO, sets run, tops up while count below depth.
// R19: In sleep the engine freezes and resumes from the same state.
// R20: Idle-stop set halts engine in idle like sleep; clear keeps running.
// R21: Pending interrupt still passes out while halted in idle.
// R22: Reset: empty one; full, count, run, length zero; status read-only.
// R23: Words shift MSb first through LFSR with XOR at enabled taps.
module crcg_top (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic [1:0] ADDR_IN,
  input wire logic [15:0] WDATA_IN,
  input wire logic [1:0] BYTE_EN_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic SLEEP_IN,
  input wire logic IDLE_IN,
  output logic [15:0] RDATA_OUT,
  output logic CRC_IRQ_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic [4:0] fifo_depth(input logic [3:0] p);
    // R5: depth from length
    fifo_depth = (p > crcg_pkg::POLY_LENGTH_MINUS_ONE_SHORT_MAX) ? crcg_pkg::DEPTH_LONG
                                                : crcg_pkg::DEPTH_SHORT;
  endfunction : fifo_depth

  function automatic logic [15:0] len_mask(input logic [3:0] p);
    len_mask = crcg_pkg::ALL_ONES >> (crcg_pkg::POLY_LENGTH_MINUS_ONE_TOP - p);
  endfunction : len_mask

  function automatic logic [15:0] crc_step(
    input logic [15:0] c,
    input logic d,
    input logic [15:0] t,
    input logic [3:0] p
  );
    logic [15:0] r;
    logic fb;
    r = '0;
    fb = 1'b0;
    // R4: top term implied
    fb = c[p] ^ d;
    r = {c[14:0], 1'b0};
    // R23: XOR at taps
    r = r ^ ({16{fb}} & t & crcg_pkg::TAPS_MASK);
    // R3: x0 term always
    r[0] = fb;
    crc_step = r & len_mask(p);
  endfunction : crc_step

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [3:0] poly_length_minus_one_q;
  logic run_q;
  logic idle_stop_q;
  logic [15:0] taps_q;
  logic [15:0] crc_q;
  logic [15:0] stage_q;
  logic [15:0] fifo_mem [crcg_pkg::FIFO_ENTRIES];
  logic [3:0] wr_ptr_q;
  logic [3:0] rd_ptr_q;
  logic [3:0] bit_cnt_q;
  logic [4:0] count_q;
  logic [4:0] count_d;
  logic irq_q;
  logic [15:0] rdata_q;
  logic [4:0] depth;
  logic full;
  logic empty;
  logic freeze;
  logic wr_ctrl;
  logic wr_taps;
  logic wr_sum;
  logic wr_fifo;
  logic msb_lane;
  logic push;
  logic wrap;
  logic shifting;
  logic pop;
  logic [3:0] bit_idx;
  logic shift_bit;
  logic [15:0] merged;
  logic [15:0] ctrl_view;

  ////////////////////////////////////////////////////////////////////////////
  // Decode and status

  assign wr_ctrl = WR_IN && (ADDR_IN == crcg_pkg::ADDR_CTRL);
  assign wr_taps = WR_IN && (ADDR_IN == crcg_pkg::ADDR_TAPS);
  assign wr_sum = WR_IN && (ADDR_IN == crcg_pkg::ADDR_CHECKSUM);
  assign wr_fifo = WR_IN && (ADDR_IN == crcg_pkg::ADDR_FIFO_WR);

  assign depth = fifo_depth(poly_length_minus_one_q);
  // R11: full and empty flags
  assign full = (count_q == depth);
  assign empty = (count_q == 5'h00);

  // R19: sleep freeze
  // R20: idle stop acts as sleep
  assign freeze = SLEEP_IN | (IDLE_IN & idle_stop_q);

  // R6: byte lanes merged
  assign merged = {BYTE_EN_IN[1] ? WDATA_IN[15:8] : stage_q[15:8],
                   BYTE_EN_IN[0] ? WDATA_IN[7:0] : stage_q[7:0]};
  assign msb_lane = (poly_length_minus_one_q > crcg_pkg::POLY_LENGTH_MINUS_ONE_SHORT_MAX);
  // R7: word done on MSb lane
  assign push = wr_fifo && BYTE_EN_IN[msb_lane];
  // R12: write while full wraps
  assign wrap = push && full;

  // R8: run and words present
  // R14: run bit gates shifter
  assign shifting = run_q && !empty && !freeze;
  assign bit_idx = poly_length_minus_one_q - bit_cnt_q;
  assign shift_bit = fifo_mem[rd_ptr_q][bit_idx];
  // R9: last bit leaves
  assign pop = shifting && (bit_cnt_q == poly_length_minus_one_q) && !wrap;

  always_comb begin
    count_d = count_q;
    if (wrap) begin
      count_d = 5'h00;
    end else if (push && !pop) begin
      count_d = count_q + 5'h01;
    end else if (pop && !push) begin
      count_d = count_q - 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  // R22: control reset values
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      poly_length_minus_one_q <= crcg_pkg::POLY_LENGTH_MINUS_ONE_RST;
      run_q <= crcg_pkg::RUN_RST;
      idle_stop_q <= crcg_pkg::IDLE_STOP_RST;
    end else if (wr_ctrl) begin
      // R1: length field
      poly_length_minus_one_q <= WDATA_IN[crcg_pkg::POLY_LENGTH_MINUS_ONE_LSB +: 4];
      run_q <= WDATA_IN[crcg_pkg::RUN_BIT];
      idle_stop_q <= WDATA_IN[crcg_pkg::IDLE_STOP_BIT];
    end
  end

  // R2: tap enables, bit 0 absent
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      taps_q <= crcg_pkg::TAPS_RST;
    end else if (wr_taps) begin
      taps_q <= WDATA_IN & crcg_pkg::TAPS_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // FIFO

  always_ff @(posedge CLK_IN) begin
    if (push && !wrap) begin
      fifo_mem[wr_ptr_q] <= merged;
    end
  end

  // R6: partial bytes held
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      stage_q <= 16'h0000;
    end else if (wr_fifo) begin
      stage_q <= push ? 16'h0000 : merged;
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      wr_ptr_q <= 4'h0;
      rd_ptr_q <= 4'h0;
    end else if (wrap) begin
      wr_ptr_q <= 4'h0;
      rd_ptr_q <= 4'h0;
    end else begin
      if (push) begin
        wr_ptr_q <= (5'(wr_ptr_q) == depth - 5'h01) ? 4'h0 : wr_ptr_q + 4'h1;
      end
      if (pop) begin
        rd_ptr_q <= (5'(rd_ptr_q) == depth - 5'h01) ? 4'h0 : rd_ptr_q + 4'h1;
      end
    end
  end

  // R7: count up on push
  // R9: count down on pop
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      count_q <= 5'h00;
    end else begin
      count_q <= count_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial shifter and CRC engine

  // R10: one bit per clock
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      bit_cnt_q <= 4'h0;
    end else if (wrap || pop) begin
      bit_cnt_q <= 4'h0;
    end else if (shifting) begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end
  end

  // R23: MSb first into LFSR
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      crc_q <= crcg_pkg::CRC_RST;
    end else if (wr_sum) begin
      crc_q <= WDATA_IN & len_mask(poly_length_minus_one_q);
    end else if (shifting && !wrap) begin
      crc_q <= crc_step(crc_q, shift_bit, taps_q, poly_length_minus_one_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt

  // R13: one to zero pulse
  // R21: not gated by freeze
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (count_q == 5'h01) && (count_d == 5'h00) && !wrap;
    end
  end

  assign CRC_IRQ_OUT = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Read port

  // R22: status fields read-only
  always_comb begin
    ctrl_view = 16'h0000;
    ctrl_view[crcg_pkg::POLY_LENGTH_MINUS_ONE_LSB +: 4] = poly_length_minus_one_q;
    ctrl_view[crcg_pkg::RUN_BIT] = run_q;
    ctrl_view[crcg_pkg::EMPTY_BIT] = empty;
    ctrl_view[crcg_pkg::FULL_BIT] = full;
    ctrl_view[crcg_pkg::COUNT_LSB +: 5] = count_q;
    ctrl_view[crcg_pkg::IDLE_STOP_BIT] = idle_stop_q;
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rdata_q <= 16'h0000;
    end else if (RD_IN) begin
      unique case (ADDR_IN)
        crcg_pkg::ADDR_CTRL: rdata_q <= ctrl_view;
        crcg_pkg::ADDR_TAPS: rdata_q <= taps_q;
        crcg_pkg::ADDR_CHECKSUM: rdata_q <= crc_q;
        crcg_pkg::ADDR_FIFO_WR: rdata_q <= crc_q;
      endcase
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  assign RDATA_OUT = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (RST_IN);

  a_count_push_up: assert property ( // R7
    push && !full && !pop |=> count_q == $past(count_q) + 5'h01)
    else $error("count did not rise on push");

  a_wrap_to_zero: assert property ( // R12
    wrap |=> count_q == 5'h00 && !CRC_IRQ_OUT)
    else $error("full write did not wrap quietly");

  a_irq_one_zero: assert property ( // R13
    CRC_IRQ_OUT |-> $past(count_q) == 5'h01 && count_q == 5'h00)
    else $error("interrupt without one to zero");

  a_irq_on_drain: assert property ( // R13
    count_q == 5'h01 && pop && !push |=> CRC_IRQ_OUT)
    else $error("drain to zero gave no interrupt");

  a_flags_depth: assert property ( // R11
    full == (count_q == ((poly_length_minus_one_q > 4'h7) ? 5'h08 : 5'h10)))
    else $error("full flag wrong for depth");

  a_no_run_hold: assert property ( // R8
    !run_q && !wrap && !push |=> count_q == $past(count_q))
    else $error("count moved while stopped");

  a_pop_last_bit: assert property ( // R10
    pop && poly_length_minus_one_q != 4'h0 && $past(shifting) && !$past(wr_ctrl)
      |-> $past(bit_cnt_q) == poly_length_minus_one_q - 4'h1)
    else $error("pop before word shifted");

  a_word_cycles: assert property ( // R10
    shifting && bit_cnt_q == 4'h0 && poly_length_minus_one_q == 4'h3 && !wr_ctrl
      ##1 shifting [*3] |-> pop)
    else $error("word not done in length plus one");

  a_freeze_hold: assert property ( // R19
    freeze && !wr_sum |=> crc_q == $past(crc_q))
    else $error("crc moved while frozen");

  a_tap_bit0: assert property ( // R2
    $past(RD_IN && ADDR_IN == 2'h1) |-> !RDATA_OUT[0])
    else $error("tap bit 0 not zero");

  c_wrap: cover property (wrap);
  c_irq: cover property (CRC_IRQ_OUT);
  c_full: cover property (full && run_q);
  c_idle_frozen: cover property (IDLE_IN && idle_stop_q && run_q && !empty);

endmodule : crcg_top

/* File: tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  logic clk, rst, wr, rd, sleep, idle, irq;
  logic [1:0] addr, be;
  logic [15:0] wdata, rdata, v, exp_c, taps, msk, d;
  logic [31:0] lfsr_q;
  int fail_count, total_checks, irq_cnt, k, n, ic;
  logic [3:0] p;

  crcg_top crcg_top_inst (.CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr),
    .WDATA_IN(wdata), .BYTE_EN_IN(be), .WR_IN(wr), .RD_IN(rd),
    .SLEEP_IN(sleep), .IDLE_IN(idle), .RDATA_OUT(rdata),
    .CRC_IRQ_OUT(irq));

  ////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
  end

  function automatic logic [15:0] rnd();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q[15:0];
  endfunction : rnd

  // Bitwise model, MSb first, feedback at enabled taps
  function automatic logic [15:0] crc_model(input logic [15:0] c,
      input logic [15:0] dw, input logic [15:0] t, input logic [3:0] pl);
    logic fb;
    for (int i = 15; i >= 0; i--) begin
      if (i <= pl) begin
        fb = c[pl] ^ dw[i];
        c = {c[14:0], fb} ^ (fb ? (t & 16'hFFFE) : 16'h0000);
      end
    end
    return c & ((17'h1_0000 << 0) >> (15 - pl)) - 16'h0001;
  endfunction : crc_model

  ////////////////////////////////////////////////////////////
  task automatic check_val(input string nm, input logic [15:0] e,
      input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : check_val

  task automatic check_cnt(input string nm, input int e, input int g);
    total_checks++;
    if (g != e) begin
      fail_count++;
      $display("wrong value %s expected %0d seen %0d", nm, e, g);
    end
  endtask : check_cnt

  task automatic bus_wr(input logic [1:0] a, input logic [15:0] dv,
      input logic [1:0] b);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= dv;
    be <= b;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= rnd();
  endtask : bus_wr

  task automatic bus_rd(input logic [1:0] a, output logic [15:0] q);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    q = rdata;
  endtask : bus_rd

  task automatic wait_irq(output int c);
    c = 0;
    do begin
      @(posedge clk);
      #1;
      c++;
    end while (irq !== 1'b1 && c < 400);
  endtask : wait_irq

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    results();
  end

  ////////////////////////////////////////////////////////////
  initial begin
    lfsr_q = 32'hd008_e113;
    rst = 1'b1;
    {wr, rd, sleep, idle} = 4'h0;
    addr = 2'h0;
    wdata = 16'h0000;
    be = 2'h0;
    fail_count = 0;
    total_checks = 0;
    irq_cnt = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    bus_rd(2'h0, v);
    check_val("ctrl reset", 16'h0040, v);
    bus_rd(2'h1, v);
    check_val("taps reset", 16'h0000, v);
    bus_wr(2'h1, 16'hFFFF, 2'h3);
    bus_rd(2'h1, v);
    check_val("taps bit0", 16'hFFFE, v);
    bus_wr(2'h0, 16'hC0E3, 2'h3);
    bus_rd(2'h0, v);
    check_val("ctrl status ro", 16'h0043, v);
    // Random polynomials, lengths and words
    for (int it = 0; it < 8; it++) begin
      p = (it == 0) ? 4'hF : (it == 1) ? 4'h3 : 4'(rnd());
      taps = (it == 0) ? 16'h1020 : rnd();
      msk = (17'h1_0000 >> (15 - p)) - 16'h0001;
      exp_c = rnd() & msk;
      n = 1 + (rnd() % 3);
      idle <= it[0];
      bus_wr(2'h0, {12'h000, p}, 2'h3);
      bus_wr(2'h1, taps, 2'h3);
      bus_wr(2'h2, exp_c, 2'h3);
      for (int w = 0; w < n; w++) begin
        d = rnd() & msk;
        bus_wr(2'h3, d, (p > 4'h7) ? 2'h3 : 2'h1);
        exp_c = crc_model(exp_c, d, taps, p);
      end
      bus_wr(2'h0, {12'h001, p}, 2'h3);
      wait_irq(k);
      check_cnt("shift cycles", n * (p + 1), k);
      bus_rd(2'h2, v);
      check_val("checksum", exp_c, v);
      bus_rd(2'h0, v);
      check_val("ctrl done", {12'h005, p}, v);
    end
    idle <= 1'b0;
    // Fill to depth, then one more write wraps
    for (int j = 0; j < 2; j++) begin
      p = j ? 4'h8 : 4'h3;
      n = j ? 8 : 16;
      bus_wr(2'h0, {12'h000, p}, 2'h3);
      for (int w = 0; w < n; w++) bus_wr(2'h3, rnd(), 2'h3);
      bus_rd(2'h0, v);
      check_val("ctrl full", {n[7:0], 8'h80} | p, v);
      ic = irq_cnt;
      bus_wr(2'h3, rnd(), 2'h3);
      bus_rd(2'h0, v);
      check_val("ctrl wrap", {12'h004, p}, v);
      check_cnt("wrap irq", ic, irq_cnt);
    end
    // Byte lanes then freeze in sleep and idle
    bus_wr(2'h0, 16'h000B, 2'h3);
    bus_wr(2'h1, 16'h0802, 2'h3);
    bus_wr(2'h2, 16'h0000, 2'h3);
    bus_wr(2'h3, 16'h00AB, 2'h1);
    bus_rd(2'h0, v);
    check_val("ctrl low byte", 16'h004B, v);
    bus_wr(2'h3, 16'h0C00, 2'h2);
    bus_rd(2'h0, v);
    check_val("ctrl high byte", 16'h010B, v);
    exp_c = crc_model(16'h0000, 16'h0CAB, 16'h0802, 4'hB);
    for (int m = 0; m < 2; m++) begin
      if (m == 0) sleep <= 1'b1;
      else idle <= 1'b1;
      bus_wr(2'h0, m ? 16'h205B : 16'h005B, 2'h3);
      repeat (20) @(posedge clk);
      bus_rd(2'h0, v);
      check_val("ctrl frozen", m ? 16'h211B : 16'h011B, v);
      sleep <= 1'b0;
      idle <= 1'b0;
      wait_irq(k);
      check_cnt("resume cycles", 12, k);
      bus_rd(2'h2, v);
      check_val("checksum resumed", exp_c, v);
      bus_wr(2'h0, 16'h000B, 2'h3);
      bus_wr(2'h3, 16'h0CAB, 2'h3);
      exp_c = crc_model(exp_c, 16'h0CAB, 16'h0802, 4'hB);
    end
    for (int w = 0; w < 3; w++) begin
      d = rnd() & 16'h0FFF;
      bus_wr(2'h3, d, 2'h3);
      exp_c = crc_model(exp_c, d, 16'h0802, 4'hB);
    end
    bus_wr(2'h0, 16'h001B, 2'h3);
    for (int w = 0; w < 4; w++) begin
      bus_rd(2'h0, v);
      if (v[12:8] < 5'h08) begin
        d = rnd() & 16'h0FFF;
        bus_wr(2'h3, d, 2'h3);
        exp_c = crc_model(exp_c, d, 16'h0802, 4'hB);
      end
    end
    for (int t = 0; t < 200 && !v[6]; t++) begin
      bus_rd(2'h0, v);
    end
    check_val("ctrl drained", 16'h005B, v);
    bus_rd(2'h2, v);
    check_val("checksum streamed", exp_c, v);
    bus_rd(2'h3, v);
    check_val("fifo index read", exp_c, v);
    results();
  end
endmodule : tb_top
